// File: verilog/unit_clock_gating_ctrl.sv
// Overview of operation
// - Bit one forces unit clock running
// - Absent compression bit reads zero, unconnected
// - Second render register, bits 18:0 used
// - RAM bank bit one keeps clock running
// - RAM register exists on mobile variant only
// - Mode selects zero, one or two units
// - Sixteen bit register, lock freezes fields
// - Units re-enabled once throttle reaches threshold
// - Threshold code selects 12.5 percent band
// - First render register at 0x6204, reset zero
module unit_clock_gating_ctrl
    import unit_clock_gating_pkg::*;
#(
    parameter bit HAS_RAM_GATING = 1'b1,
    parameter bit HAS_FBC = 1'b1,
    parameter int NUM_EU_GATE = 2
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lock_pin,
    input wire logic engine_active,
    input wire logic [6:0] engine_throttle_pct,
    input wire logic [31:0] render_one_enable,
    input wire logic [31:0] render_two_enable,
    input wire logic [31:0] ram_bank_enable,
    output logic [31:0] render_one_clk_run,
    output logic [31:0] render_two_clk_run,
    output logic [31:0] ram_bank_clk_run,
    output logic [1:0] exec_unit_gate_allow
);
    if (NUM_EU_GATE != 2) begin : g_eu_count_check
        $error("NUM_EU_GATE must be 2");
    end

    typedef struct packed {
        logic [31:0] render_one;
        logic [31:0] render_two;
        logic [31:0] ram_bank;
        logic [15:0] dyn_eu;
        logic [1:0] lock_sync;
        logic [1:0] active_sync;
        logic [13:0] pct_sync;
        logic [6:0] pct_hold;
        logic [31:0] rdata;
        logic [31:0] run_one;
        logic [31:0] run_two;
        logic [31:0] run_ram;
        logic [1:0] gate_allow;
    } state_s;

    state_s state_q;
    state_s state_d;
    logic [2:0] band;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
            input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction : merge

    function automatic logic mapped(input logic [15:0] a);
        return a == ADDR_RENDER_ONE || a == ADDR_RENDER_TWO || a == ADDR_DYN_EU || a == ADDR_EU_STATUS
            || (HAS_RAM_GATING && a == ADDR_RAM_BANK);
    endfunction : mapped

    function automatic logic [1:0] mode_mask(input logic [1:0] mode);
        logic [1:0] allow;
        case (mode)
            EU_MODE_NONE: begin
                allow = 2'h0;
            end
            EU_MODE_ATMOST_ONE: begin
                allow = 2'h1;
            end
            EU_MODE_ATLEAST_ONE: begin
                allow = 2'h1;
            end
            EU_MODE_TWO: begin
                allow = 2'h3;
            end
            default: begin
                allow = 2'h0;
            end
        endcase
        return allow;
    endfunction : mode_mask

    // Band is taken from the held percentage, never from a word in flight
    throttle_band throttle_band_inst (
        .throttle_pct(state_q.pct_hold),
        .band(band)
    );

    logic [31:0] mask_one;
    logic [15:0] dyn_mask;
    logic [31:0] dyn_word;
    logic access;
    logic wr_access;
    logic rd_setup;
    logic throttle_met;
    logic [2:0] threshold;

    always_comb begin
        state_d = state_q;
        mask_one = MASK_RENDER_ONE;
        if (!HAS_FBC) begin
            mask_one[FBC_BIT] = 1'b0;
        end
        access = psel && penable;
        wr_access = access && pwrite;
        rd_setup = psel && !penable && !pwrite;
        dyn_word = 32'h0000_0000;
        state_d.lock_sync = {state_q.lock_sync[0], lock_pin};
        state_d.active_sync = {state_q.active_sync[0], engine_active};
        state_d.pct_sync = {state_q.pct_sync[6:0], engine_throttle_pct};
        // Percentage crosses as a word: take it only once two samples agree
        if (state_q.pct_sync[13:7] == state_q.pct_sync[6:0]) begin
            state_d.pct_hold = state_q.pct_sync[13:7];
        end
        threshold = state_q.dyn_eu[THR_MSB:THR_LSB];
        throttle_met = band >= threshold;
        dyn_mask = state_q.lock_sync[1] ? MASK_DYN_EU_LOCKED : MASK_DYN_EU;
        if (wr_access) begin
            case (paddr)
                ADDR_RENDER_ONE: begin
                    state_d.render_one = merge(state_q.render_one, pwdata, pstrb, mask_one);
                end
                ADDR_RENDER_TWO: begin
                    state_d.render_two = merge(state_q.render_two, pwdata, pstrb, MASK_RENDER_TWO);
                end
                ADDR_RAM_BANK: begin
                    if (HAS_RAM_GATING) begin
                        state_d.ram_bank = merge(state_q.ram_bank, pwdata, pstrb, MASK_RAM_BANK);
                    end
                end
                ADDR_DYN_EU: begin
                    dyn_word = merge({16'h0000, state_q.dyn_eu}, pwdata, pstrb, {16'h0000, dyn_mask});
                    state_d.dyn_eu = dyn_word[15:0] | (state_q.dyn_eu & ~dyn_mask);
                end
                default: begin
                    state_d.rdata = state_q.rdata;
                end
            endcase
        end
        if (rd_setup) begin
            case (paddr)
                ADDR_RENDER_ONE: begin
                    state_d.rdata = state_q.render_one;
                end
                ADDR_RENDER_TWO: begin
                    state_d.rdata = state_q.render_two;
                end
                ADDR_RAM_BANK: begin
                    state_d.rdata = HAS_RAM_GATING ? state_q.ram_bank : 32'h0000_0000;
                end
                ADDR_DYN_EU: begin
                    state_d.rdata = {16'h0000, state_q.dyn_eu};
                end
                ADDR_EU_STATUS: begin
                    state_d.rdata = {27'h0, throttle_met, band, state_q.active_sync[1]};
                end
                default: begin
                    state_d.rdata = 32'h0000_0000;
                end
            endcase
        end
        state_d.run_one = state_q.render_one | render_one_enable;
        state_d.run_two = state_q.render_two | render_two_enable;
        state_d.run_ram = HAS_RAM_GATING ? (state_q.ram_bank | ram_bank_enable) : ram_bank_enable;
        state_d.gate_allow = mode_mask(state_q.dyn_eu[1:0]);
        // Engine-driven mode: gate only while active and below threshold
        if (state_q.dyn_eu[2]) begin
            if (!state_q.active_sync[1] || throttle_met) begin
                state_d.gate_allow = 2'h0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q <= '0;
            state_q.render_one <= RESET_RENDER_ONE;
            state_q.render_two <= RESET_RENDER_TWO;
            state_q.ram_bank <= RESET_RAM_BANK;
            state_q.dyn_eu <= RESET_DYN_EU;
        end else begin
            state_q <= state_d;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = state_q.rdata;
    assign render_one_clk_run = state_q.run_one;
    assign render_two_clk_run = state_q.run_two;
    assign ram_bank_clk_run = state_q.run_ram;
    assign exec_unit_gate_allow = state_q.gate_allow;
endmodule : unit_clock_gating_ctrl

// File: verilog/unit_clock_gating_pkg.sv
package unit_clock_gating_pkg;
    localparam logic [15:0] ADDR_RENDER_ONE = 16'h6204;
    localparam logic [15:0] ADDR_RENDER_TWO = 16'h6208;
    localparam logic [15:0] ADDR_RAM_BANK = 16'h6210;
    localparam logic [15:0] ADDR_DYN_EU = 16'h6214;
    localparam logic [15:0] ADDR_EU_STATUS = 16'h6218;
    localparam logic [31:0] RESET_RENDER_ONE = 32'h0000_0000;
    localparam logic [31:0] RESET_RENDER_TWO = 32'h0000_0000;
    localparam logic [31:0] RESET_RAM_BANK = 32'h0000_0000;
    localparam logic [15:0] RESET_DYN_EU = 16'h0000;
    localparam logic [31:0] MASK_RENDER_ONE = 32'h7FE3_F87F;
    localparam logic [31:0] MASK_RENDER_TWO = 32'h0007_FFFF;
    localparam logic [31:0] MASK_RAM_BANK = 32'hFFFF_FFFF;
    localparam logic [15:0] MASK_DYN_EU = 16'hE01F;
    localparam logic [15:0] MASK_DYN_EU_LOCKED = 16'hE013;
    localparam int FBC_BIT = 16;
    localparam int THR_LSB = 13;
    localparam int THR_MSB = 15;
    localparam int LOCK_BIT = 7;
    localparam logic [1:0] EU_MODE_NONE = 2'h0;
    localparam logic [1:0] EU_MODE_ATMOST_ONE = 2'h1;
    localparam logic [1:0] EU_MODE_ATLEAST_ONE = 2'h2;
    localparam logic [1:0] EU_MODE_TWO = 2'h3;
endpackage : unit_clock_gating_pkg

// File: verilog/throttle_band.sv
module throttle_band
    import unit_clock_gating_pkg::*;
(
    input wire logic [6:0] throttle_pct,
    output logic [2:0] band
);
    // Eight 12.5 percent bands, in eighths compared as pct*8/100
    logic [9:0] scaled;
    always_comb begin
        scaled = 10'(throttle_pct) * 10'h008;
        if (throttle_pct >= 7'h64) begin
            band = 3'h7;
        end else begin
            band = 3'(scaled / 10'h064);
        end
    end
endmodule : throttle_band

// File: verif/unit_clock_gating_properties.sv
module unit_clock_gating_props
    import unit_clock_gating_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [31:0] render_one_clk_run,
    input wire logic [31:0] render_two_clk_run,
    input wire logic [31:0] ram_bank_clk_run,
    input wire logic [1:0] exec_unit_gate_allow
);
    wire logic wr = psel && penable && pwrite && pstrb == 4'hF;
    wire logic rd = psel && !penable && !pwrite;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    one_run_a: assert property (wr && paddr == ADDR_RENDER_ONE |-> ##2
        (render_one_clk_run & $past(pwdata, 2) & MASK_RENDER_ONE) == ($past(pwdata, 2) & MASK_RENDER_ONE))
        else $error("render one run bit low");
    two_run_a: assert property (wr && paddr == ADDR_RENDER_TWO |-> ##2
        (render_two_clk_run & $past(pwdata, 2) & MASK_RENDER_TWO) == ($past(pwdata, 2) & MASK_RENDER_TWO))
        else $error("render two run bit low");
    ram_run_a: assert property (wr && paddr == ADDR_RAM_BANK |-> ##2
        (ram_bank_clk_run & $past(pwdata, 2)) == $past(pwdata, 2)) else $error("ram run bit low");
    unmapped_err_a: assert property (psel && penable && paddr == 16'h6300 |-> pslverr)
        else $error("no error on unmapped");
    unmapped_zero_a: assert property (rd && paddr == 16'h6300 |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    two_reserved_a: assert property (rd && paddr == ADDR_RENDER_TWO |=> prdata[31:19] == 13'h0)
        else $error("render two reserved bits set");
    dyn_width_a: assert property (rd && paddr == ADDR_DYN_EU |=> prdata[31:16] == 16'h0)
        else $error("dynamic register wider than 16");
    reset_clear_a: assert property ($rose(rstn) |-> exec_unit_gate_allow == 2'h0 && ram_bank_clk_run == 32'h0)
        else $error("outputs not clear after reset");
    gate_mask_a: assert property (exec_unit_gate_allow != 2'h2)
        else $error("second unit gated alone");
endmodule : unit_clock_gating_props

// File: verif/unit_clock_gating_ctrl_tb.sv
module unit_clock_gating_ctrl_tb import unit_clock_gating_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [15:0] a; logic [31:0] d; logic [31:0] e;} row_s;
    logic clk_sys, rstn, psel, penable, pwrite, pslverr, pready, lock_pin, engine_active;
    logic [6:0] engine_throttle_pct;
    logic [3:0] pstrb;
    logic [1:0] gate_exp [4] = '{2'h0, 2'h1, 2'h1, 2'h3};
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd, render_one_enable, render_one_clk_run, render_two_clk_run, ram_bank_clk_run;
    logic [1:0] exec_unit_gate_allow;
    int n_mismatch, tests_run;
    row_s rows [5];
    unit_clock_gating_ctrl unit_clock_gating_ctrl_inst (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .lock_pin, .engine_active, .engine_throttle_pct,
        .render_one_enable, .render_two_enable(32'h0), .ram_bank_enable(32'h0), .render_one_clk_run,
        .render_two_clk_run, .ram_bank_clk_run, .exec_unit_gate_allow);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            final_report();
        end
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    initial begin
        {rstn, psel, penable, pwrite, lock_pin, engine_active} = 6'h00;
        engine_throttle_pct = 7'h00;
        pstrb = 4'hF;
        paddr = 16'h0;
        pwdata = 32'h0;
        render_one_enable = 32'h0;
        rows = '{'{ADDR_RENDER_ONE, 32'hFFFF_FFFF, MASK_RENDER_ONE}, '{ADDR_RENDER_TWO, 32'hFFFF_FFFF,
            MASK_RENDER_TWO}, '{ADDR_RAM_BANK, 32'hFFFF_FFFF, MASK_RAM_BANK}, '{ADDR_DYN_EU, 32'hFFFF_FFFF,
            {16'h0, MASK_DYN_EU}}, '{16'h6300, 32'hFFFF_FFFF, 32'h0}};
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, rd);
            apb(1'b0, rows[i].a, 32'h0, rd);
            chk("readback", rd, rows[i].e);
        end
        lock_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        apb(1'b1, ADDR_DYN_EU, 32'h0, rd);
        apb(1'b0, ADDR_DYN_EU, 32'h0, rd);
        chk("locked", rd, 32'h0000_000C);
        apb(1'b1, ADDR_RENDER_ONE, 32'h7080_4001, rd);
        render_one_enable <= 32'h0000_0180;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("run", render_one_clk_run, 32'h7080_4181);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0, rd);
            chk("reset", rd, 32'h0);
        end
        lock_pin <= 1'b0;
        pstrb <= 4'h5;
        apb(1'b1, ADDR_RENDER_TWO, 32'hFFFF_FFFF, rd);
        pstrb <= 4'hF;
        apb(1'b0, ADDR_RENDER_TWO, 32'h0, rd);
        chk("strobe", rd, 32'h0007_00FF);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_DYN_EU, 32'(m), rd);
            @(posedge clk_sys);
            chk("mode", 32'(exec_unit_gate_allow), 32'(gate_exp[m]));
        end
        engine_active <= 1'b1;
        engine_throttle_pct <= 7'h0A;
        apb(1'b1, ADDR_DYN_EU, 32'h0000_2007, rd);
        repeat (6) @(posedge clk_sys);
        chk("below", 32'(exec_unit_gate_allow), 32'h0000_0003);
        apb(1'b0, ADDR_EU_STATUS, 32'h0, rd);
        chk("status", rd, 32'h0000_0001);
        engine_throttle_pct <= 7'h3C;
        repeat (6) @(posedge clk_sys);
        chk("met", 32'(exec_unit_gate_allow), 32'h0000_0000);
        apb(1'b0, ADDR_EU_STATUS, 32'h0, rd);
        chk("band", rd, 32'h0000_0019);
        engine_active <= 1'b0;
        engine_throttle_pct <= 7'h0A;
        repeat (6) @(posedge clk_sys);
        chk("idle", 32'(exec_unit_gate_allow), 32'h0000_0000);
        final_report();
    end
endmodule : unit_clock_gating_ctrl_tb
bind unit_clock_gating_ctrl unit_clock_gating_props unit_clock_gating_props_inst (.clk_sys, .rstn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .render_one_clk_run, .render_two_clk_run, .ram_bank_clk_run,
    .exec_unit_gate_allow);
